// *** kds_top.sv ***
// Keyboard/display scanner: host port, key scan, FIFO/sensor RAM, display refresh
// Notes on behaviour
// - Bus drivers only on selected reads.
// - Command/data select picks command/status or data.
// - Command taken at write strobe end, then applied.
// - Clock divided by programmable prescaler 2 to 31.
// - Counters give 5.1 ms scan; debounce 10.3 ms encoded, 5.1 ms decoded.
// - Encoded scan drives binary count.
// - Decoded scan one-of-four, display four characters.
// - Closure debounced then queued with modifiers.
// - Entry holds 6-bit position plus modifiers.
// - Sensor rows copied each key scan time until a change, again after end interrupt or clear.
// - Strobe rising edge queues return lines.
// - Queue tracks count, full, empty, errors.
// - Overrun flagged beyond eight unread entries.
// - Status read with select high.
// - Keyboard interrupt while data, drops per read.
// - Sensor change raises interrupt.
// - Display RAM read/write with auto-increment.
// - Digit nibbles follow scan, blank independently.
// - Blank output between digits and on command.
// - Shift level stored with key closure.
// - Reset returns device to reset state.
// - Left or right entry, nibble inhibit.
// - Prescaler resets to 31, clear keeps it.
// - Queue read advances pointer only when not empty.
`timescale 1ns/1ps
module kds_top (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic wr_b,
    input wire logic cmd_data_sel,
    input wire logic [kds_pkg::DATA_W-1:0] host_data_bus_in,
    output logic [kds_pkg::DATA_W-1:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic interrupt,
    input wire logic [kds_pkg::DATA_W-1:0] return_lines,
    input wire logic shift_in,
    input wire logic modifier_strobe_input,
    output logic [kds_pkg::SCAN_W-1:0] scan_lines,
    output logic [kds_pkg::NIB_W-1:0] digit_upper_nibble_out,
    output logic [kds_pkg::NIB_W-1:0] digit_lower_nibble_out,
    output logic blank_display_n
);
    import kds_pkg::*;

    function automatic logic [7:0] code_of(input logic [1:0] sel);
        code_of = (sel == CODE_ONES_SEL) ? CODE_ONES : (sel == CODE_SPACE_SEL) ? CODE_SPACE : CODE_ZERO;
    endfunction : code_of

    function automatic logic [2:0] low_col(input logic [7:0] r);
        low_col = 3'h0;
        for (int i = DATA_W - 1; i >= 0; i--)
            if (!r[i])
                low_col = 3'(i);
    endfunction : low_col

    logic [3:0] host_s;
    logic [7:0] data_s;
    logic [9:0] pin_s;
    kds_timing_if tif();

    kds_sync #(.W(4), .RESET_VAL(HOST_IDLE)) u_host_sync (.clock(clock), .rst_b(rst_b),
        .async_in({cs_b, rd_b, wr_b, cmd_data_sel}), .sync_out(host_s));
    kds_sync #(.W(DATA_W), .RESET_VAL(CODE_ZERO)) u_data_sync (.clock(clock), .rst_b(rst_b),
        .async_in(host_data_bus_in), .sync_out(data_s));
    kds_sync #(.W(10), .RESET_VAL(PIN_IDLE)) u_pin_sync (.clock(clock), .rst_b(rst_b),
        .async_in({modifier_strobe_input, shift_in, return_lines}), .sync_out(pin_s));
    kds_timing u_timing (.clock(clock), .rst_b(rst_b), .tif(tif));

    logic rd_act_ff;
    logic wr_act_ff;
    logic rd_cd_ff;
    logic wr_cd_ff;
    logic strobe_ff;
    logic restart_ff;
    logic [7:0] wr_data_ff;
    logic [4:0] prescale_ff;
    logic [1:0] dd_ff;
    logic [2:0] kmode_ff;
    logic rd_src_disp_ff;
    logic sens_ai_ff;
    logic [2:0] sens_row_ff;
    logic disp_ai_ff;
    logic [3:0] disp_addr_ff;
    logic iw_a_ff;
    logic iw_b_ff;
    logic bl_a_ff;
    logic bl_b_ff;
    logic [7:0] blank_code_ff;
    logic clearing_ff;
    logic [7:0] mem_ff [0:FIFO_DEPTH-1];
    logic [2:0] wp_ff;
    logic [2:0] rp_ff;
    logic [3:0] fcnt_ff;
    logic overrun_ff;
    logic underrun_ff;
    logic sens_inh_ff;
    kds_deb_t deb_ff;
    logic [2:0] key_row_ff;
    logic [2:0] key_col_ff;
    logic [2:0] visits_ff;
    logic [7:0] disp_ff [0:DISP_DEPTH-1];

    // Host strobe decode on synchronised levels
    wire cd_s = host_s[0];
    wire rd_act = !host_s[3] && !host_s[2];
    wire wr_act = !host_s[3] && !host_s[1];
    wire rd_start = rd_act && !rd_act_ff;
    wire rd_end = rd_act_ff && !rd_act;
    wire wr_end = wr_act_ff && !wr_act;
    wire cmd_wr = wr_end && wr_cd_ff;
    wire data_wr = wr_end && !wr_cd_ff;
    wire data_rd_end = rd_end && !rd_cd_ff;
    wire [2:0] cmd_op = wr_data_ff[CMD_MSB:CMD_LSB];
    wire cmd_clear = cmd_wr && (cmd_op == CMD_CLEAR);
    wire clr_all = cmd_clear && wr_data_ff[CLR_A_BIT];
    wire clr_fifo = cmd_clear && (wr_data_ff[CLR_F_BIT] || wr_data_ff[CLR_A_BIT]);
    wire clr_disp = cmd_clear && (wr_data_ff[CLR_D_EN_BIT] || wr_data_ff[CLR_A_BIT]);
    wire end_int = cmd_wr && (cmd_op == CMD_END_INT);
    wire [7:0] clr_code = code_of(wr_data_ff[CLR_D_EN_BIT] ? wr_data_ff[3:2] : 2'h0);

    // Mode decode
    wire decoded = kmode_ff[KM_DEC_BIT];
    wire sens_mode = (kmode_ff[2:1] == KM_SENSOR);
    wire strb_mode = (kmode_ff[2:1] == KM_STROBE);
    wire kb_mode = !kmode_ff[2];
    wire fifo_mode = !sens_mode;
    wire right_entry = dd_ff[1];
    wire [4:0] disp_len = decoded ? DISP_LEN_DEC : dd_ff[0] ? DISP_LEN_LONG : DISP_LEN_SHORT;
    wire [3:0] right_pos = 4'(disp_len - 5'h01);

    // Scan side; returns seen at digit start still show the last row
    wire [7:0] ret_s = pin_s[7:0];
    wire shift_s = pin_s[8];
    wire strobe_s = pin_s[9];
    wire [2:0] row = decoded ? {1'b0, tif.scan_cnt[1:0] - 2'h1} : tif.scan_cnt[2:0] - 3'h1;
    wire any_closed = ~&ret_s;
    wire key_still = !ret_s[key_col_ff];
    wire at_key_row = tif.digit_start && (row == key_row_ff);
    wire key_push = kb_mode && (deb_ff == DEB_WAIT) && at_key_row && key_still && (visits_ff == VISITS_LAST);
    wire stb_push = strb_mode && strobe_s && !strobe_ff;
    wire push = key_push || stb_push;
    wire [7:0] push_data = stb_push ? ret_s : {strobe_s, shift_s, key_row_ff, key_col_ff};

    // Queue bookkeeping
    wire fifo_empty = (fcnt_ff == 4'h0);
    wire fifo_full = (fcnt_ff == 4'(FIFO_DEPTH));
    wire pop_req = data_rd_end && !rd_src_disp_ff && fifo_mode;
    wire do_pop = pop_req && !fifo_empty;
    wire do_push = push && !fifo_full;
    wire [3:0] nxt_fcnt = clr_fifo ? 4'h0 : (do_push && !do_pop) ? fcnt_ff + 4'h1 :
        (do_pop && !do_push) ? fcnt_ff - 4'h1 : fcnt_ff;
    wire fifo_rd_busy = rd_act && !cd_s && !rd_src_disp_ff;

    // Sensor RAM
    wire sens_wr = sens_mode && tif.digit_start && !sens_inh_ff;
    wire sens_chg = sens_wr && (mem_ff[row] != ret_s);
    wire nxt_sens_inh = sens_chg || (sens_inh_ff && !(end_int || clr_fifo));

    wire [7:0] status = {clearing_ff, sens_inh_ff, overrun_ff, underrun_ff, fifo_full, fcnt_ff[2:0]};
    wire [7:0] rd_word = cd_s ? status : rd_src_disp_ff ? disp_ff[disp_addr_ff] :
        sens_mode ? mem_ff[sens_row_ff] : mem_ff[rp_ff];
    wire disp_wr = data_wr && !clearing_ff;
    wire disp_inc = disp_ai_ff && ((disp_wr && !right_entry) || (data_rd_end && rd_src_disp_ff));
    wire [3:0] pos = decoded ? {2'h0, tif.scan_cnt[1:0]} : tif.scan_cnt;

    assign tif.prescale = prescale_ff;
    assign tif.restart = restart_ff;

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_act_ff <= 1'b0;
            wr_act_ff <= 1'b0;
            rd_cd_ff <= 1'b0;
            wr_cd_ff <= 1'b0;
            strobe_ff <= 1'b1;
            wr_data_ff <= '0;
            restart_ff <= 1'b0;
        end
        else
        begin
            rd_act_ff <= rd_act;
            wr_act_ff <= wr_act;
            strobe_ff <= strobe_s;
            if (rd_start)
                rd_cd_ff <= cd_s;
            if (wr_act)
            begin
                wr_cd_ff <= cd_s;
                wr_data_ff <= data_s;
            end
            restart_ff <= clr_all;
        end
    end

    // Command decode; clear leaves the prescaler alone
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prescale_ff <= PRESCALE_RESET;
            dd_ff <= '0;
            kmode_ff <= '0;
            rd_src_disp_ff <= 1'b0;
            sens_ai_ff <= 1'b0;
            disp_ai_ff <= 1'b0;
            disp_addr_ff <= '0;
            {iw_a_ff, iw_b_ff, bl_a_ff, bl_b_ff} <= '0;
            blank_code_ff <= CODE_ZERO;
        end
        else
        begin
            if (cmd_wr && (cmd_op == CMD_MODE))
                {dd_ff, kmode_ff} <= wr_data_ff[DD_RIGHT_BIT:0];
            if (cmd_wr && (cmd_op == CMD_CLOCK))
                prescale_ff <= wr_data_ff[PRE_W-1:0];
            if (cmd_wr && (cmd_op == CMD_RD_FIFO))
            begin
                rd_src_disp_ff <= 1'b0;
                sens_ai_ff <= wr_data_ff[AI_BIT];
            end
            if (cmd_wr && ((cmd_op == CMD_RD_DISP) || (cmd_op == CMD_WR_DISP)))
            begin
                disp_ai_ff <= wr_data_ff[AI_BIT];
                disp_addr_ff <= wr_data_ff[3:0];
            end
            else if (disp_inc)
                disp_addr_ff <= disp_addr_ff + 4'h1;
            if (cmd_wr && (cmd_op == CMD_RD_DISP))
                rd_src_disp_ff <= 1'b1;
            if (cmd_wr && (cmd_op == CMD_INHIBIT))
                {iw_a_ff, iw_b_ff, bl_a_ff, bl_b_ff} <= wr_data_ff[IW_A_BIT:BL_B_BIT];
            if (cmd_clear)
                blank_code_ff <= code_of(wr_data_ff[3:2]);
        end
    end

    // Key debounce
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            deb_ff <= DEB_IDLE;
            key_row_ff <= '0;
            key_col_ff <= '0;
            visits_ff <= '0;
        end
        else if (!kb_mode || restart_ff)
            deb_ff <= DEB_IDLE;
        else if (tif.digit_start)
        begin
            case (deb_ff)
                DEB_IDLE:
                    if (any_closed)
                    begin
                        deb_ff <= DEB_WAIT;
                        key_row_ff <= row;
                        key_col_ff <= low_col(ret_s);
                        visits_ff <= '0;
                    end
                DEB_WAIT:
                    if (row == key_row_ff)
                    begin
                        if (!key_still)
                            deb_ff <= DEB_IDLE;
                        else if (visits_ff == VISITS_LAST)
                            deb_ff <= DEB_HELD;
                        else
                            visits_ff <= visits_ff + 3'h1;
                    end
                DEB_HELD:
                    if ((row == key_row_ff) && !key_still)
                        deb_ff <= DEB_IDLE;
                default:
                    deb_ff <= DEB_IDLE;
            endcase
        end
    end

    // Queue, sensor RAM and status flags; a flag set wins over its clear
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            mem_ff <= '{default: '0};
            wp_ff <= '0;
            rp_ff <= '0;
            fcnt_ff <= '0;
            overrun_ff <= 1'b0;
            underrun_ff <= 1'b0;
            sens_inh_ff <= 1'b0;
            sens_row_ff <= '0;
            interrupt <= 1'b0;
        end
        else
        begin
            if (sens_wr)
                mem_ff[row] <= ret_s;
            else if (do_push)
                mem_ff[wp_ff] <= push_data;
            wp_ff <= clr_fifo ? 3'h0 : do_push ? wp_ff + 3'h1 : wp_ff;
            rp_ff <= clr_fifo ? 3'h0 : do_pop ? rp_ff + 3'h1 : rp_ff;
            fcnt_ff <= nxt_fcnt;
            overrun_ff <= (push && fifo_full) || (overrun_ff && !clr_fifo);
            underrun_ff <= (pop_req && fifo_empty) || (underrun_ff && !clr_fifo);
            sens_inh_ff <= nxt_sens_inh;
            if (cmd_wr && (cmd_op == CMD_RD_FIFO))
                sens_row_ff <= wr_data_ff[2:0];
            else if (clr_fifo)
                sens_row_ff <= 3'h0;
            else if (data_rd_end && !rd_src_disp_ff && sens_mode && sens_ai_ff)
                sens_row_ff <= sens_row_ff + 3'h1;
            interrupt <= sens_mode ? nxt_sens_inh : ((nxt_fcnt != 4'h0) && !fifo_rd_busy);
        end
    end

    // Display RAM
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            disp_ff <= '{default: '0};
            clearing_ff <= 1'b0;
        end
        else
        begin
            clearing_ff <= clr_disp || (clearing_ff && !tif.scan_wrap);
            if (clr_disp)
                disp_ff <= '{default: clr_code};
            else if (disp_wr && right_entry)
            begin
                for (int i = 0; i < DISP_DEPTH - 1; i++)
                begin
                    if (5'(i + 1) < disp_len)
                    begin
                        if (!iw_a_ff)
                            disp_ff[i][7:4] <= disp_ff[i + 1][7:4];
                        if (!iw_b_ff)
                            disp_ff[i][3:0] <= disp_ff[i + 1][3:0];
                    end
                end
                if (!iw_a_ff)
                    disp_ff[right_pos][7:4] <= wr_data_ff[7:4];
                if (!iw_b_ff)
                    disp_ff[right_pos][3:0] <= wr_data_ff[3:0];
            end
            else if (disp_wr)
            begin
                if (!iw_a_ff)
                    disp_ff[disp_addr_ff][7:4] <= wr_data_ff[7:4];
                if (!iw_b_ff)
                    disp_ff[disp_addr_ff][3:0] <= wr_data_ff[3:0];
            end
        end
    end

    // Pin outputs
    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            host_data_bus_out <= '0;
            host_data_bus_oe <= 1'b0;
            scan_lines <= '0;
            digit_upper_nibble_out <= '0;
            digit_lower_nibble_out <= '0;
            blank_display_n <= 1'b0;
        end
        else
        begin
            host_data_bus_oe <= rd_act;
            if (rd_start)
                host_data_bus_out <= rd_word;
            scan_lines <= decoded ? 4'(4'h1 << tif.scan_cnt[1:0]) : tif.scan_cnt;
            digit_upper_nibble_out <= bl_a_ff ? blank_code_ff[7:4] : disp_ff[pos][7:4];
            digit_lower_nibble_out <= bl_b_ff ? blank_code_ff[3:0] : disp_ff[pos][3:0];
            blank_display_n <= !(tif.blank_win || (bl_a_ff && bl_b_ff));
        end
    end
endmodule : kds_top

// *** kds_pkg.sv ***
// Shared constants and types for the keyboard/display scanner
package kds_pkg;
    localparam int DATA_W = 8;
    localparam int SCAN_W = 4;
    localparam int NIB_W = 4;
    localparam int PRE_W = 5;
    localparam int TICK_W = 5;
    localparam int FIFO_DEPTH = 8;
    localparam int DISP_DEPTH = 16;
    // Timing: internal tick 10 us at the nominal 100 kHz
    localparam int TICK_US = 10;
    localparam int SCAN_PERIOD_US = 5100;
    localparam int DEBOUNCE_US = 10300;
    localparam int DIGIT_TICKS = 32;
    localparam int KEY_ROWS = 8;
    localparam int DEBOUNCE_VISITS = DEBOUNCE_US / (TICK_US * DIGIT_TICKS * KEY_ROWS);
    localparam logic [2:0] VISITS_LAST = 3'(DEBOUNCE_VISITS - 1);
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(DIGIT_TICKS - 1);
    localparam logic [TICK_W-1:0] BLANK_TICKS = 5'h02;
    localparam logic [SCAN_W-1:0] SCAN_LAST = 4'hf;
    localparam logic [PRE_W-1:0] PRESCALE_RESET = 5'h1f;
    localparam logic [PRE_W-1:0] PRESCALE_MIN = 5'h02;
    // Command word layout
    localparam int CMD_MSB = 7;
    localparam int CMD_LSB = 5;
    localparam int AI_BIT = 4;
    localparam logic [2:0] CMD_MODE = 3'h0;
    localparam logic [2:0] CMD_CLOCK = 3'h1;
    localparam logic [2:0] CMD_RD_FIFO = 3'h2;
    localparam logic [2:0] CMD_RD_DISP = 3'h3;
    localparam logic [2:0] CMD_WR_DISP = 3'h4;
    localparam logic [2:0] CMD_INHIBIT = 3'h5;
    localparam logic [2:0] CMD_CLEAR = 3'h6;
    localparam logic [2:0] CMD_END_INT = 3'h7;
    localparam int IW_A_BIT = 3;
    localparam int IW_B_BIT = 2;
    localparam int BL_A_BIT = 1;
    localparam int BL_B_BIT = 0;
    localparam int CLR_D_EN_BIT = 4;
    localparam int CLR_F_BIT = 1;
    localparam int CLR_A_BIT = 0;
    localparam logic [1:0] CODE_SPACE_SEL = 2'h2;
    localparam logic [1:0] CODE_ONES_SEL = 2'h3;
    localparam logic [7:0] CODE_ZERO = 8'h00;
    localparam logic [7:0] CODE_SPACE = 8'h20;
    localparam logic [7:0] CODE_ONES = 8'hff;
    // Mode fields: DD in [4:3], KKK in [2:0]
    localparam int DD_RIGHT_BIT = 4;
    localparam int DD_LONG_BIT = 3;
    localparam int KM_DEC_BIT = 0;
    localparam logic [1:0] KM_SENSOR = 2'h2;
    localparam logic [1:0] KM_STROBE = 2'h3;
    localparam logic [4:0] DISP_LEN_DEC = 5'h04;
    localparam logic [4:0] DISP_LEN_SHORT = 5'h08;
    localparam logic [4:0] DISP_LEN_LONG = 5'h10;
    localparam logic [3:0] HOST_IDLE = 4'he;
    localparam logic [9:0] PIN_IDLE = 10'h3ff;
    typedef enum logic [1:0] {
        DEB_IDLE = 2'b00,
        DEB_WAIT = 2'b01,
        DEB_HELD = 2'b10
    } kds_deb_t;
endpackage : kds_pkg

// *** kds_timing_if.sv ***
// Timing chain signals between the scanner core and its divider
`timescale 1ns/1ps
interface kds_timing_if;
    logic [4:0] prescale;
    logic restart;
    logic [3:0] scan_cnt;
    logic digit_start;
    logic scan_wrap;
    logic blank_win;
    modport timer (input prescale, input restart, output scan_cnt, output digit_start, output scan_wrap,
        output blank_win);
    modport user (output prescale, output restart, input scan_cnt, input digit_start, input scan_wrap,
        input blank_win);
endinterface : kds_timing_if

// *** kds_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module kds_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] s1_ff;
    logic [W-1:0] s2_ff;
    logic [W-1:0] s3_ff;
    wire [W-1:0] agree = ~(s2_ff ^ s3_ff);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s1_ff <= RESET_VAL;
            s2_ff <= RESET_VAL;
            s3_ff <= RESET_VAL;
            sync_out <= RESET_VAL;
        end
        else
        begin
            s1_ff <= async_in;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            sync_out <= (s3_ff & agree) | (sync_out & ~agree);
        end
    end
endmodule : kds_sync

// *** kds_timing.sv ***
// Prescaler and scan counter chain
`timescale 1ns/1ps
module kds_timing (
    input wire logic clock,
    input wire logic rst_b,
    kds_timing_if.timer tif
);
    import kds_pkg::*;

    logic [PRE_W-1:0] pre_ff;
    logic [TICK_W-1:0] tick_ff;
    logic [SCAN_W-1:0] cnt_ff;
    logic start_ff;
    logic wrap_ff;
    // Illegal divisors below the minimum run at the minimum
    wire [PRE_W-1:0] div_last = (tif.prescale < PRESCALE_MIN) ? PRESCALE_MIN - 5'h01 : tif.prescale - 5'h01;
    wire tick_en = (pre_ff == div_last);
    wire digit_end = tick_en && (tick_ff == TICK_LAST);

    assign tif.scan_cnt = cnt_ff;
    assign tif.digit_start = start_ff;
    assign tif.scan_wrap = wrap_ff;
    assign tif.blank_win = (tick_ff < BLANK_TICKS);

    always_ff @(posedge clock or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pre_ff <= '0;
            tick_ff <= '0;
            cnt_ff <= '0;
            start_ff <= 1'b0;
            wrap_ff <= 1'b0;
        end
        else if (tif.restart)
        begin
            pre_ff <= '0;
            tick_ff <= '0;
            cnt_ff <= '0;
            start_ff <= 1'b0;
            wrap_ff <= 1'b0;
        end
        else
        begin
            pre_ff <= tick_en ? '0 : pre_ff + 5'h01;
            if (tick_en)
                tick_ff <= digit_end ? '0 : tick_ff + 5'h01;
            if (digit_end)
                cnt_ff <= cnt_ff + 4'h1;
            start_ff <= digit_end;
            wrap_ff <= digit_end && (cnt_ff == SCAN_LAST);
        end
    end
endmodule : kds_timing

// *** kds_top_properties.sv ***
// Port-level timing checks for the keyboard/display scanner
`timescale 1ns/1ps
module kds_props (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic rd_b,
    input wire logic cmd_data_sel,
    input wire logic [kds_pkg::DATA_W-1:0] host_data_bus_out,
    input wire logic host_data_bus_oe,
    input wire logic interrupt,
    input wire logic [kds_pkg::SCAN_W-1:0] scan_lines,
    input wire logic blank_display_n
);
    import kds_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence s_rd_held;
        (!rd_b && !cs_b) [*6];
    endsequence
    sequence s_data_rd;
        host_data_bus_oe && !cmd_data_sel && !cs_b;
    endsequence
    property p_rd_answer; s_rd_held |-> host_data_bus_oe; endproperty
    property p_idle_quiet; cs_b [*6] |-> !host_data_bus_oe; endproperty
    property p_rd_release; $rose(rd_b) |-> ##[0:6] !host_data_bus_oe; endproperty
    property p_data_steady; host_data_bus_oe && $past(host_data_bus_oe) |-> $stable(host_data_bus_out); endproperty
    property p_oe_cause; $rose(host_data_bus_oe) |-> $past(!rd_b && !cs_b, 3); endproperty
    property p_scan_hold; $changed(scan_lines) |=> $stable(scan_lines) [*8]; endproperty
    property p_blank_switch; $changed(scan_lines) |-> ##[0:2] !blank_display_n; endproperty
    property p_int_drop; s_data_rd ##1 s_data_rd |-> !interrupt; endproperty
    a_rd_answer: assert property (p_rd_answer) else $error("no read answer");
    a_idle_quiet: assert property (p_idle_quiet) else $error("bus driven unselected");
    a_rd_release: assert property (p_rd_release) else $error("bus held after read");
    a_data_steady: assert property (p_data_steady) else $error("read data moved");
    a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
    a_scan_hold: assert property (p_scan_hold) else $error("scan step too short");
    a_blank_switch: assert property (p_blank_switch) else $error("no blank at digit switch");
    a_int_drop: assert property (p_int_drop) else $error("interrupt high in data read");
endmodule : kds_props
bind kds_top kds_props i_kds_props (.clock(clock), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b),
    .cmd_data_sel(cmd_data_sel), .host_data_bus_out(host_data_bus_out), .host_data_bus_oe(host_data_bus_oe),
    .interrupt(interrupt), .scan_lines(scan_lines), .blank_display_n(blank_display_n));

// *** kds_keypad.sv ***
// Key matrix and strobed source model on the scan side
`timescale 1ns/1ps
module kds_keypad (
    input wire logic [kds_pkg::SCAN_W-1:0] scan_lines,
    input wire logic key_down,
    input wire logic [2:0] key_row,
    input wire logic [2:0] key_col,
    input wire logic strobed,
    input wire logic [kds_pkg::DATA_W-1:0] strobe_val,
    output logic [kds_pkg::DATA_W-1:0] return_lines
);
    import kds_pkg::*;
    // Open switches read high through the pull-ups
    wire logic hit = key_down && scan_lines[2:0] == key_row;
    assign return_lines = strobed ? strobe_val : ~(8'(hit) << key_col);
endmodule : kds_keypad

// *** kds_tb.sv ***
// Self-checking bench for the keyboard/display scanner
`timescale 1ns/1ps
module tb;
    import kds_pkg::*;
    logic clock = 1'b0, rst_b = 1'b0, cs_b = 1'b1, rd_b = 1'b1, wr_b = 1'b1, cmd_data_sel = 1'b0;
    logic [7:0] host_data_bus_in = 8'h00, host_data_bus_out, rl, strobe_val = 8'h00;
    logic host_data_bus_oe, interrupt, shift_in = 1'b0, cntl = 1'b0, key_down = 1'b0, strobed = 1'b0;
    logic [3:0] scan_lines, up_nib, lo_nib;
    logic blank_display_n;
    int fails = 0, n_tests = 0, cyc = 0;
    always #5 clock = ~clock;
    kds_top i_kds_top (.clock(clock), .rst_b(rst_b), .cs_b(cs_b), .rd_b(rd_b), .wr_b(wr_b),
        .cmd_data_sel(cmd_data_sel), .host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe), .interrupt(interrupt), .return_lines(rl), .shift_in(shift_in),
        .modifier_strobe_input(cntl), .scan_lines(scan_lines), .digit_upper_nibble_out(up_nib),
        .digit_lower_nibble_out(lo_nib), .blank_display_n(blank_display_n));
    kds_keypad i_kds_keypad (.scan_lines(scan_lines), .key_down(key_down), .key_row(3'h3), .key_col(3'h5),
        .strobed(strobed), .strobe_val(strobe_val), .return_lines(rl));
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : step
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
            fails++;
        end
    endtask : chk
    // Strobes held 8 clocks so the synchroniser cannot miss them
    task automatic host(input logic cd, input logic wr, input logic [7:0] d, output logic [7:0] q);
        cmd_data_sel = cd;
        host_data_bus_in = d;
        cs_b = 1'b0;
        wr_b = !wr;
        rd_b = wr;
        step(8);
        q = host_data_bus_oe ? host_data_bus_out : 8'hxx;
        wr_b = 1'b1;
        rd_b = 1'b1;
        cs_b = 1'b1;
        host_data_bus_in = ~d;
        step(8);
    endtask : host
    task automatic wr(input logic cd, input logic [7:0] d);
        logic [7:0] q;
        host(cd, 1'b1, d, q);
    endtask : wr
    task automatic rd(input string what, input logic cd, input logic [7:0] exp);
        logic [7:0] q;
        host(cd, 1'b0, 8'h00, q);
        chk(what, 16'(exp), 16'(q));
    endtask : rd
    task automatic t_reset;
        chk("oe", 16'h0000, 16'(host_data_bus_oe));
        chk("int", 16'h0000, 16'(interrupt));
        rd("status", 1'b1, 8'h00);
        $display("reset test done");
    endtask : t_reset
    task automatic t_scan(input logic [7:0] cmd, input int per);
        logic [3:0] s;
        int n;
        if (cmd != 8'h00)
            wr(1'b1, cmd);
        s = scan_lines;
        for (n = 0; n < 2100 && scan_lines === s; n++) step(1);
        s = scan_lines;
        for (n = 0; n < 2100 && scan_lines === s; n++) step(1);
        chk("digit period", 16'(per), 16'(n));
        chk("scan count", 16'(s + 4'h1), 16'(scan_lines));
        $display("scan test done");
    endtask : t_scan
    task automatic t_key;
        int n;
        shift_in = 1'b1;
        key_down = 1'b1;
        step(2000);
        chk("early int", 16'h0000, 16'(interrupt));
        for (n = 0; n < 3000 && interrupt !== 1'b1; n++) step(1);
        chk("int", 16'h0001, 16'(interrupt));
        rd("status", 1'b1, 8'h01);
        rd("key", 1'b0, 8'h5d);
        chk("int after pop", 16'h0000, 16'(interrupt));
        key_down = 1'b0;
        shift_in = 1'b0;
        rd("status", 1'b1, 8'h00);
        $display("key test done");
    endtask : t_key
    task automatic t_under;
        logic [7:0] q;
        host(1'b0, 1'b0, 8'h00, q);
        rd("status", 1'b1, 8'h10);
        t_scan(8'hc2, 64);
        rd("status", 1'b1, 8'h00);
        $display("underrun test done");
    endtask : t_under
    task automatic t_strobe;
        wr(1'b1, 8'h06);
        strobed = 1'b1;
        for (int i = 0; i < 9; i++)
        begin
            strobe_val = 8'(8'h1d * i + 8'h03);
            step(8);
            cntl = 1'b1;
            step(8);
            cntl = 1'b0;
        end
        rd("status", 1'b1, 8'h28);
        for (int i = 0; i < 8; i++)
            rd("strobed entry", 1'b0, 8'(8'h1d * i + 8'h03));
        rd("status", 1'b1, 8'h20);
        $display("strobe test done");
    endtask : t_strobe
    task automatic t_disp;
        wr(1'b1, 8'h90);
        wr(1'b0, 8'ha5);
        wr(1'b0, 8'h3c);
        wr(1'b1, 8'h70);
        rd("disp0", 1'b0, 8'ha5);
        rd("disp1", 1'b0, 8'h3c);
        for (int n = 0; n < 1100 && !(scan_lines === 4'h1 && blank_display_n === 1'b1); n++) step(1);
        chk("digit", 16'h003c, 16'({up_nib, lo_nib}));
        wr(1'b1, 8'ha3);
        for (int n = 0; n < 1100 && scan_lines !== 4'h0; n++) step(1);
        step(8);
        chk("blanked", 16'h0000, 16'({up_nib, lo_nib}));
        $display("display test done");
    endtask : t_disp
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            fails++;
            final_report;
        end
    end
    initial
    begin
        step(3);
        rst_b = 1'b1;
        step(2);
        t_reset;
        t_scan(8'h00, 992);
        t_scan(8'h22, 64);
        t_key;
        t_under;
        t_strobe;
        t_disp;
        final_report;
    end
endmodule : tb
